//--- dlar_pkg.sv
package dlar_pkg;

   // ---------------------------------------------------------------
   // Widths
   // ---------------------------------------------------------------
   localparam int unsigned ADDR_W    = 8;
   localparam int unsigned DATA_W    = 32;
   localparam int unsigned CNT_W     = 16;
   localparam int unsigned TMR_W     = 24;
   localparam int unsigned PERSIST_W = 4;
   localparam int unsigned BADDR_W   = 7;
   localparam int unsigned NCHAN     = 2;

   // ---------------------------------------------------------------
   // Timing: integration times in microseconds, clock in MHz
   // ---------------------------------------------------------------
   localparam int unsigned CLK_MHZ        = 25;
   localparam int unsigned ITIME_SHORT_US = 13700;
   localparam int unsigned ITIME_MED_US   = 101000;
   localparam int unsigned ITIME_LONG_US  = 402000;
   localparam int unsigned ITIME_SHORT_CYC = ITIME_SHORT_US * CLK_MHZ;
   localparam int unsigned ITIME_MED_CYC   = ITIME_MED_US * CLK_MHZ;
   localparam int unsigned ITIME_LONG_CYC  = ITIME_LONG_US * CLK_MHZ;

   // Serial bus rate ceilings per variant, in kHz
   localparam int unsigned SMBUS_MAX_KHZ = 100;
   localparam int unsigned I2C_MAX_KHZ   = 400;

   // ---------------------------------------------------------------
   // Integration time codes and full-scale counts
   // ---------------------------------------------------------------
   localparam logic [1:0]       ITIME_SHORT = 2'h0;
   localparam logic [1:0]       ITIME_MED   = 2'h1;
   localparam logic [CNT_W-1:0] FULL_LONG   = 16'hFFFF;
   localparam logic [CNT_W-1:0] FULL_MED    = 16'h9139;
   localparam logic [CNT_W-1:0] FULL_SHORT  = 16'h13B7;

   // Low gain counts one converter pulse in sixteen
   localparam logic [3:0] GAIN_LOW_DIV = 4'hF;

   // Persistence limits
   localparam logic [PERSIST_W-1:0] PERSIST_MAX = 4'hF;
   localparam logic [PERSIST_W-1:0] PERSIST_MIN = 4'h1;

   // Address strap settle count after reset release
   localparam logic [1:0] STRAP_SETTLE = 2'h3;

   // ---------------------------------------------------------------
   // Register offsets (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [ADDR_W-1:0] REG_CTRL     = 8'h00;
   localparam logic [ADDR_W-1:0] REG_THR_LO   = 8'h04;
   localparam logic [ADDR_W-1:0] REG_THR_HI   = 8'h08;
   localparam logic [ADDR_W-1:0] REG_DATA0    = 8'h0C;
   localparam logic [ADDR_W-1:0] REG_DATA1    = 8'h10;
   localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 8'h14;
   localparam logic [ADDR_W-1:0] REG_IRQ_CLR  = 8'h18;
   localparam logic [ADDR_W-1:0] REG_IRQ_EN   = 8'h1C;
   localparam logic [ADDR_W-1:0] REG_INFO     = 8'h20;

   // Interrupt bit layout
   localparam int unsigned IRQ_W       = 2;
   localparam int unsigned IRQ_THR_BIT = 1;

   // Target addresses per strap level (values are arbitrary)
   localparam logic [BADDR_W-1:0] BUS_ADDR_LOW   = 7'h20;
   localparam logic [BADDR_W-1:0] BUS_ADDR_FLOAT = 7'h21;
   localparam logic [BADDR_W-1:0] BUS_ADDR_HIGH  = 7'h22;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [PERSIST_W-1:0] persist;
      logic                 alert_mode;
      logic [1:0]           itime;
      logic                 gain_high;
      logic                 power_on;
   } dlar_ctrl_t;

   localparam int unsigned CTRL_W     = 9;
   localparam dlar_ctrl_t  CTRL_RESET = 9'h000;

   typedef struct packed {
      logic thresh;
      logic done;
   } dlar_irq_t;

   typedef struct packed {
      logic [CNT_W-1:0] infrared_channel;
      logic [CNT_W-1:0] broadband_channel;
   } dlar_result_t;

endpackage

//--- dlar_integ.sv
module dlar_integ import dlar_pkg::*;
(
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             reset,
   // Control
   input  wire logic             run,
   input  wire logic             clear,
   input  wire logic             gain_high,
   input  wire logic [CNT_W-1:0] limit,
   // Converter pulse, already synchronised
   input  wire logic             pulse,
   // Running count
   output logic      [CNT_W-1:0] count_q
);

   logic [3:0] prescale_q;
   wire        tick;
   wire        below_limit;

   // Low gain passes one pulse in sixteen
   assign tick        = pulse && (gain_high || prescale_q == GAIN_LOW_DIV);
   assign below_limit = count_q < limit;

   // Counter saturates at the full-scale count
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         count_q    <= '0;
         prescale_q <= '0;
      end
      else if (clear || !run)
      begin
         count_q    <= '0;
         prescale_q <= '0;
      end
      else
      begin
         if (pulse)
            prescale_q <= prescale_q + 4'h1;
         if (tick && below_limit)
            count_q <= count_q + 16'h0001;
      end
   end

endmodule

//--- dlar_top.sv
module dlar_top import dlar_pkg::*;
#(
   parameter int unsigned SHORT_CYC = ITIME_SHORT_CYC,
   parameter int unsigned MED_CYC   = ITIME_MED_CYC,
   parameter int unsigned LONG_CYC  = ITIME_LONG_CYC
)
(
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              reset,
   // Register port
   input  wire logic [ADDR_W-1:0] reg_addr,
   input  wire logic [DATA_W-1:0] reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic      [DATA_W-1:0] reg_rdata_q,
   // Converter pulses from the analog side
   input  wire logic [NCHAN-1:0]  conv_pulse,
   // Address strap sense, pull-up and pull-down reads
   input  wire logic              addr_sense_up,
   input  wire logic              addr_sense_dn,
   // Alert response answered by the serial engine
   input  wire logic              alert_resp_ack,
   // Serial engine configuration
   output logic [BADDR_W-1:0]     bus_addr_q,
   output logic                   rate_fast_q,
   // Interrupt pin, open drain
   output logic                   int_pin_o_q,
   output logic                   int_pin_oe_q,
   // Interrupt to the system
   output logic                   irq_q
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   dlar_ctrl_t           ctrl_q;
   logic [CNT_W-1:0]     thr_lo_q;
   logic [CNT_W-1:0]     thr_hi_q;
   dlar_result_t         result_q;
   dlar_irq_t            irq_stat_q;
   dlar_irq_t            irq_en_q;
   logic [PERSIST_W-1:0] persist_cnt_q;
   logic [TMR_W-1:0]     timer_q;
   logic [NCHAN-1:0]     pulse_s1_q;
   logic [NCHAN-1:0]     pulse_s2_q;
   logic [NCHAN-1:0]     pulse_s3_q;
   logic                 up_s1_q;
   logic                 up_s2_q;
   logic                 dn_s1_q;
   logic                 dn_s2_q;
   logic [1:0]           settle_q;
   logic                 strap_done_q;
   logic [CNT_W-1:0]     ch_count [NCHAN];

   // ---------------------------------------------------------------
   // Register decode
   // ---------------------------------------------------------------
   wire wr_ctrl   = reg_wr && reg_addr == REG_CTRL;
   wire wr_thr_lo = reg_wr && reg_addr == REG_THR_LO;
   wire wr_thr_hi = reg_wr && reg_addr == REG_THR_HI;
   wire wr_clr    = reg_wr && reg_addr == REG_IRQ_CLR;
   wire wr_en     = reg_wr && reg_addr == REG_IRQ_EN;

   // ---------------------------------------------------------------
   // Integration timing
   // ---------------------------------------------------------------
   wire              run = ctrl_q.power_on;
   logic [TMR_W-1:0] end_cyc;
   logic [CNT_W-1:0] sat_limit;
   // Window length and full scale follow the integration time code
   always_comb
   begin
      unique case (ctrl_q.itime)
         ITIME_SHORT:
         begin
            end_cyc   = TMR_W'(SHORT_CYC - 1);
            sat_limit = FULL_SHORT;
         end
         ITIME_MED:
         begin
            end_cyc   = TMR_W'(MED_CYC - 1);
            sat_limit = FULL_MED;
         end
         default:
         begin
            end_cyc   = TMR_W'(LONG_CYC - 1);
            sat_limit = FULL_LONG;
         end
      endcase
   end
   // A configuration write restarts the window so counts stay in scale
   wire              cycle_end = run && timer_q == end_cyc;
   wire              restart   = cycle_end || wr_ctrl || !run;
   wire [TMR_W-1:0]  timer_d   = restart ? '0 : timer_q + 24'h000001;
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         timer_q <= '0;
      else
         timer_q <= timer_d;
   end

   // ---------------------------------------------------------------
   // Converter channels
   // ---------------------------------------------------------------
   genvar ch;
   generate
      for (ch = 0; ch < NCHAN; ch++)
      begin : g_chan
         // Two-stage synchroniser, third stage for edge detect
         always_ff @(posedge clk or posedge reset)
         begin
            if (reset)
            begin
               pulse_s1_q[ch] <= 1'b0;
               pulse_s2_q[ch] <= 1'b0;
               pulse_s3_q[ch] <= 1'b0;
            end
            else
            begin
               pulse_s1_q[ch] <= conv_pulse[ch];
               pulse_s2_q[ch] <= pulse_s1_q[ch];
               pulse_s3_q[ch] <= pulse_s2_q[ch];
            end
         end
         // Both channels share run, clear and gain
         dlar_integ u_integ
         (
            .clk       (clk),
            .reset     (reset),
            .run       (run),
            .clear     (restart),
            .gain_high (ctrl_q.gain_high),
            .limit     (sat_limit),
            .pulse     (pulse_s2_q[ch] && !pulse_s3_q[ch]),
            .count_q   (ch_count[ch])
         );
      end
   endgenerate

   // ---------------------------------------------------------------
   // Threshold and persistence
   // ---------------------------------------------------------------
   wire out_of_range = cycle_end &&
                       (ch_count[0] < thr_lo_q || ch_count[0] > thr_hi_q);
   wire [PERSIST_W-1:0] persist_next =
      (persist_cnt_q == PERSIST_MAX) ? PERSIST_MAX : persist_cnt_q + 4'h1;
   wire [PERSIST_W-1:0] persist_need =
      (ctrl_q.persist == '0) ? PERSIST_MIN : ctrl_q.persist;
   wire thr_event = out_of_range && persist_next >= persist_need;

   // ---------------------------------------------------------------
   // Interrupt status: set wins over clear
   // ---------------------------------------------------------------
   wire       ara_clear = alert_resp_ack && ctrl_q.alert_mode;
   dlar_irq_t irq_set;
   dlar_irq_t irq_clr;
   dlar_irq_t irq_stat_d;
   assign irq_set    = {thr_event, cycle_end};
   assign irq_clr    = (wr_clr ? dlar_irq_t'(reg_wdata[IRQ_W-1:0]) : '0) |
                       {ara_clear, 1'b0};
   assign irq_stat_d = (irq_stat_q & ~irq_clr) | irq_set;

   // ---------------------------------------------------------------
   // Read mux
   // ---------------------------------------------------------------
   logic [DATA_W-1:0] rd_mux;
   always_comb
   begin
      unique case (reg_addr)
         REG_CTRL:     rd_mux = {23'h000000, ctrl_q};
         REG_THR_LO:   rd_mux = {16'h0000, thr_lo_q};
         REG_THR_HI:   rd_mux = {16'h0000, thr_hi_q};
         REG_DATA0:    rd_mux = {16'h0000, result_q.broadband_channel};
         REG_DATA1:    rd_mux = {16'h0000, result_q.infrared_channel};
         REG_IRQ_STAT: rd_mux = {30'h00000000, irq_stat_q};
         REG_IRQ_EN:   rd_mux = {30'h00000000, irq_en_q};
         REG_INFO:     rd_mux = {17'h00000, bus_addr_q, 6'h00, rate_fast_q, run};
         default:      rd_mux = '0;
      endcase
   end

   // ---------------------------------------------------------------
   // Registers written by software
   // ---------------------------------------------------------------
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         ctrl_q   <= CTRL_RESET;
         thr_lo_q <= '0;
         thr_hi_q <= '0;
         irq_en_q <= '0;
      end
      else
      begin
         if (wr_ctrl)
            ctrl_q <= dlar_ctrl_t'(reg_wdata[CTRL_W-1:0]);
         if (wr_thr_lo)
            thr_lo_q <= reg_wdata[CNT_W-1:0];
         if (wr_thr_hi)
            thr_hi_q <= reg_wdata[CNT_W-1:0];
         if (wr_en)
            irq_en_q <= dlar_irq_t'(reg_wdata[IRQ_W-1:0]);
      end
   end

   // ---------------------------------------------------------------
   // Results, persistence, status and outputs
   // ---------------------------------------------------------------
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         result_q      <= '0;
         persist_cnt_q <= '0;
         irq_stat_q    <= '0;
         reg_rdata_q   <= '0;
         irq_q         <= 1'b0;
         int_pin_o_q   <= 1'b0;
         int_pin_oe_q  <= 1'b0;
         rate_fast_q   <= 1'b0;
      end
      else
      begin
         if (cycle_end)
         begin
            result_q.broadband_channel <= ch_count[0];
            result_q.infrared_channel  <= ch_count[1];
            persist_cnt_q <= out_of_range ? persist_next : '0;
         end
         irq_stat_q   <= irq_stat_d;
         reg_rdata_q  <= reg_rd ? rd_mux : '0;
         irq_q        <= |(irq_stat_q & irq_en_q);
         int_pin_o_q  <= 1'b0;
         int_pin_oe_q <= irq_stat_q.thresh && irq_en_q.thresh;
         rate_fast_q  <= !ctrl_q.alert_mode;
      end
   end

   // ---------------------------------------------------------------
   // Address strap capture after reset release
   // ---------------------------------------------------------------
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         up_s1_q      <= 1'b0;
         up_s2_q      <= 1'b0;
         dn_s1_q      <= 1'b0;
         dn_s2_q      <= 1'b0;
         settle_q     <= '0;
         strap_done_q <= 1'b0;
         bus_addr_q   <= BUS_ADDR_LOW;
      end
      else
      begin
         up_s1_q <= addr_sense_up;
         up_s2_q <= up_s1_q;
         dn_s1_q <= addr_sense_dn;
         dn_s2_q <= dn_s1_q;
         if (settle_q != STRAP_SETTLE)
            settle_q <= settle_q + 2'h1;
         else if (!strap_done_q)
         begin
            strap_done_q <= 1'b1;
            if (up_s2_q && dn_s2_q)
               bus_addr_q <= BUS_ADDR_HIGH;
            else if (!up_s2_q && !dn_s2_q)
               bus_addr_q <= BUS_ADDR_LOW;
            else
               bus_addr_q <= BUS_ADDR_FLOAT;
         end
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   chk_result_copy: assert property (
      cycle_end |=> result_q.broadband_channel == $past(ch_count[0]) &&
                    result_q.infrared_channel == $past(ch_count[1]))
      else $error("result not copied at cycle end");
   chk_result_hold: assert property (
      !cycle_end |=> $stable(result_q))
      else $error("result changed outside cycle end");
   chk_next_cycle: assert property (
      cycle_end ##1 run && !wr_ctrl |=> timer_q == 24'h000001)
      else $error("integration did not restart");
   chk_power_down: assert property (
      !run |=> $stable(result_q) && $stable(persist_cnt_q) && timer_q == '0)
      else $error("activity while powered down");
   chk_full_scale: assert property (
      cycle_end && !$past(wr_ctrl) |-> ch_count[0] <= sat_limit && ch_count[1] <= sat_limit)
      else $error("count above full scale");
   chk_thr_raise: assert property (
      thr_event |=> irq_stat_q.thresh ##1 (int_pin_oe_q || !$past(irq_en_q.thresh)))
      else $error("threshold event not flagged");
   chk_persist_gate: assert property (
      $rose(irq_stat_q.thresh) |-> $past(out_of_range && persist_next >= persist_need))
      else $error("interrupt before persistence met");
   chk_persist_reset: assert property (
      cycle_end && !out_of_range |=> persist_cnt_q == '0)
      else $error("persistence count not reset in range");
   chk_level_hold: assert property (
      irq_stat_q.thresh && !irq_clr.thresh |=> irq_stat_q.thresh)
      else $error("interrupt dropped without clear");
   chk_alert_release: assert property (
      ara_clear && !thr_event |=> !irq_stat_q.thresh)
      else $error("alert not released on response");
   chk_open_drain: assert property (
      int_pin_oe_q == $past(irq_stat_q.thresh && irq_en_q.thresh) && !int_pin_o_q)
      else $error("interrupt pin not following enabled status");
endmodule

//--- dlar_light_model.sv
module dlar_light_model import dlar_pkg::*;
(
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             reset,
   // Channel enables and phase length in cycles
   input  wire logic [NCHAN-1:0] en,
   input  wire logic [3:0]       half,
   // Converter pulses
   output logic      [NCHAN-1:0] pulse
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [3:0] cnt_q;

   // ----------------------------------------
   // Square wave source
   // ----------------------------------------
   // Each phase lasts half cycles; a disabled channel sits low
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         cnt_q <= 4'h0;
         pulse <= '0;
      end
      else if (cnt_q >= half - 4'h1)
      begin
         cnt_q <= 4'h0;
         pulse <= (pulse ^ en) & en;
      end
      else
         cnt_q <= cnt_q + 4'h1;
   end
endmodule

//--- tb_top.sv
module tb_top import dlar_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic              clk;
   logic              reset;
   logic [ADDR_W-1:0] reg_addr;
   logic [DATA_W-1:0] reg_wdata;
   logic              reg_wr;
   logic              reg_rd;
   logic [DATA_W-1:0] reg_rdata_q;
   logic [NCHAN-1:0]  conv_pulse;
   logic [NCHAN-1:0]  ch_en;
   logic              sense_up;
   logic              sense_dn;
   logic              ack;
   logic [BADDR_W-1:0] bus_addr_q;
   logic              rate_fast_q;
   logic              int_pin_o_q;
   logic              int_pin_oe_q;
   logic              irq_q;
   logic [DATA_W-1:0] v;
   logic [DATA_W-1:0] v_late;
   int                err_count;
   int                n_compared;

   // ----------------------------------------
   // Device and light source
   // ----------------------------------------
   dlar_top #(.SHORT_CYC(40), .MED_CYC(60), .LONG_CYC(80)) u_dlar_top (
      .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
      .conv_pulse(conv_pulse), .addr_sense_up(sense_up),
      .addr_sense_dn(sense_dn), .alert_resp_ack(ack), .bus_addr_q(bus_addr_q),
      .rate_fast_q(rate_fast_q), .int_pin_o_q(int_pin_o_q),
      .int_pin_oe_q(int_pin_oe_q), .irq_q(irq_q));

   dlar_light_model u_dlar_light_model (
      .clk(clk), .reset(reset), .en(ch_en), .half(4'h2), .pulse(conv_pulse));

   // ----------------------------------------
   // Bus tasks and comparisons
   // ----------------------------------------
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr    <= 1'b0;
   endtask

   task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
      @(posedge clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd   <= 1'b0;
      #1;
      d = reg_rdata_q;
   endtask

   task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         err_count++;
         $display("ERROR t=%0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_rng(input logic [DATA_W-1:0] got, input int lo, input int hi);
      n_compared++;
      if ((^got === 1'bx) || got < lo || got > hi)
      begin
         err_count++;
         $display("ERROR t=%0t count %h outside %0d..%0d", $time, got, lo, hi);
      end
   endtask

   // Bounded waits on the interrupt outputs
   task automatic wait_irq;
      int n;
      n = 0;
      // Let a clear just written reach the registered interrupt first
      repeat (2) @(posedge clk);
      while (irq_q !== 1'b1 && n < 300)
      begin
         @(posedge clk);
         n++;
      end
      chk(irq_q, 1'b1);
   endtask

   task automatic wait_oe;
      int n;
      n = 0;
      repeat (2) @(posedge clk);
      while (int_pin_oe_q !== 1'b1 && n < 300)
      begin
         @(posedge clk);
         n++;
      end
      chk(int_pin_oe_q, 1'b1);
   endtask

   task automatic tally_and_finish;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // ----------------------------------------
   // Clock, reset, watchdog
   // ----------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   initial
   begin
      #800000;
      err_count++;
      tally_and_finish;
   end

   // ----------------------------------------
   // Test sequence
   // ----------------------------------------
   initial
   begin
      err_count = 0;
      n_compared = 0;
      reset = 1'b1;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      ch_en = 2'h1;
      sense_up = 1'b1;
      sense_dn = 1'b1;
      ack = 1'b0;
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      repeat (5) @(posedge clk);
      chk(bus_addr_q, BUS_ADDR_HIGH);
      rd(REG_INFO, v);
      chk(v, 32'h00002202);
      chk(rate_fast_q, 1'b1);
      rd(REG_CTRL, v);
      chk(v, 32'h0);
      rd(8'h24, v);
      chk(v, 32'h0);
      // Persistence two, short window, high gain, broadband only
      wr(REG_THR_LO, 32'h0);
      wr(REG_THR_HI, 32'h2);
      wr(REG_IRQ_EN, 32'h1);
      wr(REG_CTRL, 32'h43);
      wait_irq;
      rd(REG_IRQ_STAT, v);
      chk(v, 32'h1);
      rd(REG_DATA0, v);
      chk_rng(v, 8, 11);
      rd(REG_DATA1, v);
      chk(v, 32'h0);
      wr(REG_IRQ_CLR, 32'h1);
      repeat (3) @(posedge clk);
      chk(irq_q, 1'b0);
      wait_irq;
      rd(REG_IRQ_STAT, v);
      chk(v, 32'h3);
      // Level interrupt holds through in-range cycles until cleared
      wr(REG_IRQ_EN, 32'h2);
      wr(REG_THR_HI, 32'hFFFF);
      wait_oe;
      chk(int_pin_o_q, 1'b0);
      repeat (100) @(posedge clk);
      chk(int_pin_oe_q, 1'b1);
      wr(REG_IRQ_CLR, 32'h3);
      repeat (3) @(posedge clk);
      chk(int_pin_oe_q, 1'b0);
      // Low gain counts one pulse in sixteen
      wr(REG_IRQ_EN, 32'h1);
      wr(REG_CTRL, 32'h01);
      wr(REG_IRQ_CLR, 32'h3);
      wait_irq;
      rd(REG_DATA0, v);
      chk(v, 32'h0);
      // Medium window is longer
      wr(REG_CTRL, 32'h07);
      wr(REG_IRQ_CLR, 32'h3);
      wait_irq;
      rd(REG_DATA0, v);
      chk_rng(v, 13, 16);
      // Alert variant: response acknowledge releases the pin
      wr(REG_IRQ_EN, 32'h2);
      wr(REG_THR_HI, 32'h2);
      wr(REG_CTRL, 32'h13);
      wr(REG_IRQ_CLR, 32'h3);
      wait_oe;
      wr(REG_THR_HI, 32'hFFFF);
      rd(REG_INFO, v);
      chk(v, 32'h00002201);
      chk(rate_fast_q, 1'b0);
      @(posedge clk);
      ack <= 1'b1;
      @(posedge clk);
      ack <= 1'b0;
      repeat (3) @(posedge clk);
      chk(int_pin_oe_q, 1'b0);
      // Power down freezes results while the bus still answers
      wr(REG_IRQ_EN, 32'h1);
      wr(REG_CTRL, 32'h0);
      wr(REG_IRQ_CLR, 32'h3);
      rd(REG_DATA0, v);
      repeat (150) @(posedge clk);
      chk(irq_q, 1'b0);
      rd(REG_DATA0, v_late);
      chk(v_late, v);
      // Mid-run reset with the strap left floating
      @(posedge clk);
      reset    <= 1'b1;
      sense_dn <= 1'b0;
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      repeat (5) @(posedge clk);
      chk(bus_addr_q, BUS_ADDR_FLOAT);
      tally_and_finish;
   end
endmodule
